/* logic/sleep_wake_power_controller.sv */
// Sleep and wake power mode controller with real-time counter and alarm
//
// How it works
// - Quiescent when asleep, running when awake, controlled states in between.
// - Writing the sleep bit of the control register starts sleep entry.
// - Wake stimuli act only in the asleep state.
// - A wake stimulus during sleep entry is held and acted on when asleep.
// - Wake pin rising or falling edge, chosen by software, ends sleep.
// - Counter reaching the programmed alarm ends sleep.
// - Awake, the counter adds one per main clock tick.
// - Counter keeps a fixed ratio to the core timers while awake.
// - If configured, the counter uses the slow oscillator while asleep.
// - Each slow tick adds a programmable increment to the counter.
// - Asleep, core node and peripherals are off; wake logic and counter run.
// - Losing power-good during either transition issues a system reset.
// - A 128-byte memory keeps its contents across deep sleep.
// - Watchdog enabled and clocked only while awake.
// - Memory contents are lost on a full power-down.
`timescale 1ns/100ps
`include "pwr_consts.svh"
module sleep_wake_power_controller #(
    parameter int MEM_WORDS = 32
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        wake_pin,
    input  wire logic        slow_osc,
    input  wire logic        power_good,
    // Power control outputs
    output logic             core_pwr_en,
    output logic             periph_pwr_en,
    output logic             supply1_en,
    output logic             second_buck_supply_en,
    output logic             supply_pfm,
    output logic             core_clk_mask,
    output logic             core_reset,
    output logic             sys_reset,
    output logic             watchdog_en,
    output logic             irq
);
    // ==========================================================
    // Declarations
    pwr_pkg::pwr_state_type state_ff;
    pwr_pkg::pwr_state_type nxt_state;
    logic [3:0]             step_ff;
    logic [`CFG_W-1:0]      cfg_ff;
    logic [`INT_W-1:0]      int_stat_ff;
    logic [`INT_W-1:0]      int_mask_ff;
    logic [63:0]            rtc_ff;
    logic [63:0]            nxt_rtc;
    logic [63:0]            alarm_ff;
    logic [31:0]            slow_inc_ff;
    logic                   wake_pend_ff;
    logic                   pin_d_ff;
    logic                   slow_d_ff;
    logic [31:0]            prdata_ff;
    logic                   sys_reset_ff;
    logic [2:0]             pin_s;
    logic [31:0]            mem_rdata;
    logic [31:0]            rd_mux;

    // ==========================================================
    // Pin synchronisers
    sync_2ff #(
        .W (3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({power_good, slow_osc, wake_pin}),
        .dout    (pin_s)
    );

    wire wake_s  = pin_s[0];
    wire slow_s  = pin_s[1];
    wire pgood_s = pin_s[2];

    // ==========================================================
    // APB decode
    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable;
    wire wr_en     = access_ph & pwrite;
    wire mem_sel   = paddr[7] & (paddr[1:0] == 2'h0);
    wire reg_hit   = (paddr[1:0] == 2'h0) && (paddr <= `OFS_SLOW_INC);
    wire addr_ok   = mem_sel | reg_hit;
    wire wr_ctrl   = wr_en & (paddr == `OFS_CTRL);
    wire wr_cfg    = wr_en & (paddr == `OFS_SLEEP_CFG);
    wire wr_istat  = wr_en & (paddr == `OFS_INT_STAT);
    wire wr_imask  = wr_en & (paddr == `OFS_INT_MASK);
    wire wr_rtc_lo = wr_en & (paddr == `OFS_RTC_LO);
    wire wr_rtc_hi = wr_en & (paddr == `OFS_RTC_HI);
    wire wr_alm_lo = wr_en & (paddr == `OFS_ALARM_LO);
    wire wr_alm_hi = wr_en & (paddr == `OFS_ALARM_HI);
    wire wr_inc    = wr_en & (paddr == `OFS_SLOW_INC);
    wire wr_mem    = wr_en & mem_sel;

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~addr_ok;
    assign prdata  = prdata_ff;

    assign rd_mux =
        mem_sel                      ? mem_rdata :
        (paddr == `OFS_SLEEP_CFG)    ? {24'h000000, cfg_ff} :
        (paddr == `OFS_STATUS)       ? {27'h0000000, wake_pend_ff, pgood_s, state_ff} :
        (paddr == `OFS_INT_STAT)     ? {28'h0000000, int_stat_ff} :
        (paddr == `OFS_INT_MASK)     ? {28'h0000000, int_mask_ff} :
        (paddr == `OFS_RTC_LO)       ? rtc_ff[31:0] :
        (paddr == `OFS_RTC_HI)       ? rtc_ff[63:32] :
        (paddr == `OFS_ALARM_LO)     ? alarm_ff[31:0] :
        (paddr == `OFS_ALARM_HI)     ? alarm_ff[63:32] :
        (paddr == `OFS_SLOW_INC)     ? slow_inc_ff :
                                       32'h00000000;

    // ==========================================================
    // Deep-sleep memory
    // Retained storage, untouched by power states
    dsleep_mem #(
        .DEPTH (MEM_WORDS),
        .AW    (5)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (wr_mem),
        .addr    (paddr[6:2]),
        .wdata   (pwdata),
        .rdata   (mem_rdata)
    );

    // ==========================================================
    // Wake stimuli
    wire in_awake   = (state_ff == pwr_pkg::ST_AWAKE);
    wire in_asleep  = (state_ff == pwr_pkg::ST_ASLEEP);
    wire entering   = (state_ff == pwr_pkg::ST_MASK) || (state_ff == pwr_pkg::ST_PWRDN);
    wire leaving    = (state_ff == pwr_pkg::ST_PWRUP) || (state_ff == pwr_pkg::ST_UNMASK);
    wire in_trans   = entering | leaving;
    wire pin_rise   = wake_s & ~pin_d_ff;
    wire pin_fall   = ~wake_s & pin_d_ff;
    wire pin_evt    = cfg_ff[`CFG_PIN_EN_BIT] &
                      (cfg_ff[`CFG_PIN_RISE_BIT] ? pin_rise : pin_fall);
    // Equal or above, so a large step cannot skip it
    wire alarm_hit  = rtc_ff >= alarm_ff;
    wire alarm_evt  = cfg_ff[`CFG_ALARM_EN_BIT] & alarm_hit;
    wire wake_evt   = pin_evt | alarm_evt;
    wire pfail      = in_trans & ~pgood_s;
    wire step_done  = (step_ff == 4'(`PWR_STEP_CYC - 1));
    // Sleep request honoured only when awake
    wire sleep_req  = wr_ctrl & pwdata[`CTRL_SLEEP_BIT] & in_awake;
    wire slow_tick  = slow_s & ~slow_d_ff;

    // ==========================================================
    // Power state machine
    // Controlled path between awake and asleep
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            pwr_pkg::ST_AWAKE:
                if (sleep_req) nxt_state = pwr_pkg::ST_MASK;
            // Clock mask and reset first, then supplies
            pwr_pkg::ST_MASK:
                if (pfail) nxt_state = pwr_pkg::ST_AWAKE;
                else if (step_done) nxt_state = pwr_pkg::ST_PWRDN;
            pwr_pkg::ST_PWRDN:
                if (pfail) nxt_state = pwr_pkg::ST_AWAKE;
                else if (step_done) nxt_state = pwr_pkg::ST_ASLEEP;
            // Only here do wake stimuli act
            pwr_pkg::ST_ASLEEP:
                if (wake_evt || wake_pend_ff) nxt_state = pwr_pkg::ST_PWRUP;
            // Supplies first, then clock and reset
            pwr_pkg::ST_PWRUP:
                if (pfail) nxt_state = pwr_pkg::ST_AWAKE;
                else if (step_done) nxt_state = pwr_pkg::ST_UNMASK;
            pwr_pkg::ST_UNMASK:
                if (pfail || step_done) nxt_state = pwr_pkg::ST_AWAKE;
            default:
                nxt_state = pwr_pkg::ST_AWAKE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= pwr_pkg::ST_AWAKE;
            step_ff  <= 4'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            step_ff  <= (nxt_state != state_ff) ? 4'h0 : step_ff + 4'h1;
        end
    end

    // ==========================================================
    // Wake pending and edge history
    // Stimulus during entry is held until asleep
    wire nxt_pend = in_awake ? 1'b0 :
                    in_asleep ? 1'b0 :
                    (wake_pend_ff | (entering & wake_evt));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_pend_ff <= 1'b0;
            pin_d_ff     <= 1'b0;
            slow_d_ff    <= 1'b0;
            sys_reset_ff <= 1'b0;
        end
        else
        begin
            wake_pend_ff <= nxt_pend;
            pin_d_ff     <= wake_s;
            slow_d_ff    <= slow_s;
            sys_reset_ff <= pfail;
        end
    end

    // ==========================================================
    // Power outputs
    // Core and peripherals off in the low states
    wire pwr_low = (state_ff == pwr_pkg::ST_PWRDN) || in_asleep;
    // Clock mask and reset applied in every state except ST_AWAKE and ST_UNMASK
    wire mask_on = !in_awake && (state_ff != pwr_pkg::ST_UNMASK);

    assign core_pwr_en           = ~pwr_low;
    assign periph_pwr_en         = ~pwr_low;
    assign supply1_en            = ~(pwr_low & cfg_ff[`CFG_SUP1_OFF_BIT]);
    assign second_buck_supply_en = 1'b1;
    assign supply_pfm            = pwr_low & cfg_ff[`CFG_PFM_BIT];
    assign core_clk_mask         = mask_on & cfg_ff[`CFG_CLK_MASK_BIT];
    assign core_reset            = mask_on & cfg_ff[`CFG_RST_BIT];
    assign sys_reset             = sys_reset_ff;
    assign watchdog_en           = in_awake;

    // ==========================================================
    // Real-time counter
    wire use_slow = !in_awake & cfg_ff[`CFG_SLOW_RTC_BIT];

    always_comb
    begin
        nxt_rtc = rtc_ff;
        if (wr_rtc_lo)
            nxt_rtc = {rtc_ff[63:32], pwdata};
        else if (wr_rtc_hi)
            nxt_rtc = {pwdata, rtc_ff[31:0]};
        // Slow source outside the awake state
        else if (use_slow)
        begin
            if (slow_tick) nxt_rtc = rtc_ff + {32'h00000000, slow_inc_ff};
        end
        else
            nxt_rtc = rtc_ff + 64'h0000000000000001;
    end

    // Counter runs on the same clock as the core timers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rtc_ff <= 64'h0000000000000000;
        else
            rtc_ff <= nxt_rtc;
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_ff      <= `CFG_RESET;
            int_mask_ff <= 4'h0;
            alarm_ff    <= `ALARM_RESET;
            slow_inc_ff <= `SLOW_INC_RESET;
        end
        else
        begin
            if (wr_cfg)    cfg_ff           <= pwdata[`CFG_W-1:0];
            if (wr_imask)  int_mask_ff      <= pwdata[`INT_W-1:0];
            if (wr_alm_lo) alarm_ff[31:0]   <= pwdata;
            if (wr_alm_hi) alarm_ff[63:32]  <= pwdata;
            if (wr_inc)    slow_inc_ff      <= pwdata;
        end
    end

    // ==========================================================
    // Interrupt status, set wins over write-one clear
    wire [`INT_W-1:0] int_set = {pfail,
                                 (nxt_state == pwr_pkg::ST_ASLEEP) & ~in_asleep,
                                 in_asleep & alarm_evt,
                                 in_asleep & pin_evt};
    wire [`INT_W-1:0] int_clr = wr_istat ? pwdata[`INT_W-1:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_stat_ff <= 4'h0;
            prdata_ff   <= 32'h00000000;
        end
        else
        begin
            int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
            if (setup_ph && !pwrite) prdata_ff <= rd_mux;
        end
    end

    assign irq = |(int_stat_ff & int_mask_ff);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wdog_awake: assert property (watchdog_en |-> core_pwr_en && !core_clk_mask)
        else $error("watchdog enabled while core not running");
    a_sleep_start: assert property (sleep_req |=> state_ff == pwr_pkg::ST_MASK)
        else $error("sleep request did not start entry");
    a_wake_only_asleep: assert property (
        $rose(state_ff == pwr_pkg::ST_PWRUP) |-> $past(state_ff) == pwr_pkg::ST_ASLEEP)
        else $error("wake path entered from wrong state");
    a_pend_held: assert property (
        entering && wake_evt && pgood_s |=> wake_pend_ff || in_asleep)
        else $error("wake during entry was lost");
    a_alarm_wake: assert property (
        in_asleep && cfg_ff[`CFG_ALARM_EN_BIT] && rtc_ff >= alarm_ff
        |=> state_ff == pwr_pkg::ST_PWRUP)
        else $error("alarm did not wake");
    a_rtc_awake_inc: assert property (
        in_awake && !wr_rtc_lo && !wr_rtc_hi |=> rtc_ff == $past(rtc_ff) + 64'h1)
        else $error("counter did not step by one");
    a_rtc_slow_inc: assert property (
        use_slow && slow_tick && !wr_rtc_lo && !wr_rtc_hi
        |=> rtc_ff == $past(rtc_ff) + {32'h0, $past(slow_inc_ff)})
        else $error("slow step wrong");
    a_core_off: assert property (in_asleep |-> !core_pwr_en && !periph_pwr_en)
        else $error("core powered while asleep");
    a_pfail_reset: assert property (pfail |=> sys_reset ##1 in_awake)
        else $error("power fail gave no reset");
    a_order_down: assert property (
        $rose(state_ff == pwr_pkg::ST_PWRDN) |-> $past(state_ff) == pwr_pkg::ST_MASK)
        else $error("supplies dropped before masking");

    c_sleep: cover property (in_asleep ##1 state_ff == pwr_pkg::ST_PWRUP);
    c_pend: cover property (entering && wake_evt ##[1:40] in_asleep);
    c_pfail: cover property (pfail);
    c_slow: cover property (use_slow && slow_tick);

endmodule : sleep_wake_power_controller

/* logic/pwr_consts.svh */
// Offsets, field positions, reset values and timing counts of the power controller
`ifndef PWR_CONSTS_SVH
`define PWR_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_SLEEP_CFG  8'h04
`define OFS_STATUS     8'h08
`define OFS_INT_STAT   8'h0C
`define OFS_INT_MASK   8'h10
`define OFS_RTC_LO     8'h14
`define OFS_RTC_HI     8'h18
`define OFS_ALARM_LO   8'h1C
`define OFS_ALARM_HI   8'h20
`define OFS_SLOW_INC   8'h24
`define OFS_MEM_BASE   8'h80

// ==========================================================
// Control and sleep configuration fields
`define CTRL_SLEEP_BIT      0
`define CFG_SUP1_OFF_BIT    0
`define CFG_PFM_BIT         1
`define CFG_CLK_MASK_BIT    2
`define CFG_RST_BIT         3
`define CFG_SLOW_RTC_BIT    4
`define CFG_PIN_EN_BIT      5
`define CFG_PIN_RISE_BIT    6
`define CFG_ALARM_EN_BIT    7
`define CFG_W               8
`define CFG_RESET           8'hA0

// ==========================================================
// Interrupt status fields
`define INT_PIN_BIT    0
`define INT_ALARM_BIT  1
`define INT_SLEEP_BIT  2
`define INT_PFAIL_BIT  3
`define INT_W          4

// ==========================================================
// Reset values and timing
`define SLOW_INC_RESET 32'h00000140
`define ALARM_RESET    64'hFFFFFFFFFFFFFFFF
`define CLK_PERIOD_NS  100
`define PWR_STEP_NS    1000
`define PWR_STEP_CYC   ((`PWR_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* logic/pwr_pkg.sv */
// Types shared by the power controller files
package pwr_pkg;

    // ==========================================================
    // Power states, Gray coded along the sleep and wake path
    typedef enum logic [2:0]
    {
        ST_AWAKE  = 3'h0,
        ST_MASK   = 3'h1,
        ST_PWRDN  = 3'h3,
        ST_ASLEEP = 3'h2,
        ST_PWRUP  = 3'h6,
        ST_UNMASK = 3'h4
    } pwr_state_type;

endpackage : pwr_pkg

/* logic/sync_2ff.sv */
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Level in and out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            dout    <= '0;
        end
        else
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : sync_2ff

/* logic/dsleep_mem.sv */
// Word memory kept across deep sleep, cleared only by power-on reset
`timescale 1ns/100ps
module dsleep_mem #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    logic [31:0] mem_ff [DEPTH];

    assign rdata = mem_ff[addr];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_ff[i] <= 32'h00000000;
            end
        end
        else if (we)
        begin
            mem_ff[addr] <= wdata;
        end
    end
endmodule : dsleep_mem

/* testbench/wake_pin_source.sv */
// Far side model: wake pin, slow oscillator and supply status
`timescale 1ns/100ps
module wake_pin_source (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Commands from the bench
    input  wire logic pin_req,
    input  wire logic pgood_req,
    input  wire logic slow_en,
    // Pins toward the block
    output logic      wake_pin,
    output logic      slow_osc,
    output logic      power_good
);
    // ==========================================================
    // Slow oscillator, 31,250 Hz is 160 cycles per half period
    logic [7:0] half_cnt_ff;

    assign wake_pin   = pin_req;
    assign power_good = pgood_req;

    // slow tick source, still when off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_cnt_ff <= 8'h00;
            slow_osc    <= 1'b0;
        end
        else if (slow_en)
        begin
            half_cnt_ff <= (half_cnt_ff == 8'h9F) ? 8'h00 : half_cnt_ff + 8'h01;
            if (half_cnt_ff == 8'h9F)
                slow_osc <= ~slow_osc;
        end
    end
endmodule : wake_pin_source

/* testbench/sleep_wake_power_controller_test.sv */
// Self-checking bench of the sleep and wake power controller
`timescale 1ns/100ps
`include "pwr_consts.svh"
module sleep_wake_power_controller_test;
    // ==========================================================
    // Signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pin_req, pgood_req, slow_en, wake_pin, slow_osc, power_good;
    logic core_pwr_en, periph_pwr_en, supply1_en, buck2_en, supply_pfm;
    logic core_clk_mask, core_reset, sys_reset, watchdog_en, last_err;
    int   num_errors, checks_done;

    sleep_wake_power_controller dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
        .slow_osc(slow_osc), .power_good(power_good), .core_pwr_en(core_pwr_en),
        .periph_pwr_en(periph_pwr_en), .supply1_en(supply1_en),
        .second_buck_supply_en(buck2_en), .supply_pfm(supply_pfm),
        .core_clk_mask(core_clk_mask), .core_reset(core_reset),
        .sys_reset(sys_reset), .watchdog_en(watchdog_en), .irq(irq));
    wake_pin_source far (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
        .pgood_req(pgood_req), .slow_en(slow_en), .wake_pin(wake_pin),
        .slow_osc(slow_osc), .power_good(power_good));

    // ==========================================================
    // Helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wait_wd(input logic v, input int lim);
        for (int i = 0; i < lim && watchdog_en !== v; i++)
            @(posedge pclk);
        #1 chk(watchdog_en, v);
    endtask : wait_wd

    // ==========================================================
    // Scenarios
    task t_reset;
        apb(0, `OFS_SLEEP_CFG, 0); chk(rd, 32'h000000A0);
        apb(0, `OFS_SLOW_INC, 0);  chk(rd, `SLOW_INC_RESET);
        apb(0, `OFS_ALARM_HI, 0);  chk(rd, 32'hFFFFFFFF);
        apb(0, 8'h28, 0);          chk(last_err, 1'b1);
        apb(0, 8'h81, 0);          chk(last_err, 1'b1);
        chk(pready, 1'b1);
        chk(watchdog_en, 1'b1);
    endtask : t_reset

    task t_rtc_rate;
        logic [31:0] r0;
        apb(0, `OFS_RTC_LO, 0); r0 = rd;
        apb(0, `OFS_RTC_LO, 0);
        chk(rd - r0, 32'h00000003);
    endtask : t_rtc_rate

    task t_sleep_pin;
        apb(1, `OFS_INT_MASK, 32'h00000004);
        apb(1, `OFS_SLEEP_CFG, 32'h000000EF);
        apb(1, `OFS_CTRL, 32'h00000001);
        for (int i = 0; i < 40 && core_pwr_en !== 1'b0; i++) @(posedge pclk);
        // mask and reset still on once power is off, supply 1 off, PFM on
        chk({core_clk_mask, core_reset, supply1_en, supply_pfm}, 4'hD);
        chk(periph_pwr_en, 1'b0);
        repeat (12) @(posedge pclk);
        chk(irq, 1'b1);
        apb(0, `OFS_STATUS, 0); chk(rd[2:0], 3'h2);
        apb(1, `OFS_INT_MASK, 0);
        @(posedge pclk);
        chk(irq, 1'b0);
        pin_req <= 1'b1;
        for (int i = 0; i < 40 && core_pwr_en !== 1'b1; i++) @(posedge pclk);
        #1 chk(core_clk_mask, 1'b1);
        wait_wd(1'b1, 40);
        chk({core_clk_mask, core_reset, buck2_en}, 3'h1);
        apb(0, `OFS_INT_STAT, 0); chk(rd[`INT_PIN_BIT], 1'b1);
        apb(1, `OFS_INT_STAT, 32'h0000000F);
        apb(0, `OFS_INT_STAT, 0); chk(rd[3:0], 4'h0);
    endtask : t_sleep_pin

    task t_wake_in_entry;
        apb(1, `OFS_SLEEP_CFG, 32'h000000AF);
        apb(1, `OFS_CTRL, 32'h00000001);
        pin_req <= 1'b0;
        wait_wd(1'b0, 5);
        wait_wd(1'b1, 90);
        apb(0, `OFS_INT_STAT, 0); chk(rd[2:0], 3'h4);
        apb(1, `OFS_INT_STAT, 32'h0000000F);
    endtask : t_wake_in_entry

    task t_alarm;
        logic [31:0] r0;
        apb(1, `OFS_SLEEP_CFG, 32'h0000009C);
        apb(0, `OFS_RTC_LO, 0);
        apb(1, `OFS_ALARM_LO, rd + 32'h00000300);
        apb(1, `OFS_ALARM_HI, 0);
        slow_en <= 1'b1;
        apb(1, `OFS_CTRL, 32'h00000001);
        wait_wd(1'b0, 5);
        apb(0, `OFS_RTC_LO, 0); r0 = rd;
        repeat (60) @(posedge pclk);
        apb(0, `OFS_RTC_LO, 0); chk(rd - r0, 32'h00000000);
        chk(watchdog_en, 1'b0);
        wait_wd(1'b1, 2000);
        apb(0, `OFS_INT_STAT, 0); chk(rd[`INT_ALARM_BIT], 1'b1);
        apb(1, `OFS_INT_STAT, 32'h0000000F);
        slow_en <= 1'b0;
    endtask : t_alarm

    task t_power_fail;
        apb(1, `OFS_SLEEP_CFG, 32'h0000000C);
        apb(1, `OFS_CTRL, 32'h00000001);
        pgood_req <= 1'b0;
        for (int i = 0; i < 20 && sys_reset !== 1'b1; i++)
        begin
            @(posedge pclk);
            #1;
        end
        chk(sys_reset, 1'b1);
        @(posedge pclk);
        pgood_req <= 1'b1;
        wait_wd(1'b1, 5);
        apb(0, `OFS_INT_STAT, 0); chk(rd[`INT_PFAIL_BIT], 1'b1);
    endtask : t_power_fail

    task t_memory;
        apb(1, `OFS_MEM_BASE + 8'h7C, 32'hC0DE5A5A);
        apb(0, `OFS_MEM_BASE + 8'h7C, 0); chk(rd, 32'hC0DE5A5A);
    endtask : t_memory

    task t_power_on;
        apb(1, `OFS_MEM_BASE + 8'h7C, 32'hC0DE5A5A);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFS_MEM_BASE + 8'h7C, 0); chk(rd, 32'h00000000);
        apb(0, `OFS_STATUS, 0); chk(rd[2:0], 3'h0);
    endtask : t_power_on

    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Clock, watchdog and main sequence
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        #3000000;
        num_errors++;
        give_verdict();
    end

    initial
    begin
        num_errors = 0; checks_done = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000;
        pin_req = 1'b0; pgood_req = 1'b1; slow_en = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rtc_rate();
        t_memory();
        t_sleep_pin();
        t_wake_in_entry();
        t_alarm();
        t_power_fail();
        t_memory();
        t_power_on();
        give_verdict();
    end
endmodule : sleep_wake_power_controller_test
